// ### logic/fcs_pkg.sv
package fcs_pkg;
    // =====================================
    // timing
    localparam int CLK_MHZ = 200;
    localparam int PROG_TIME_US = 40;
    localparam int ERASE_TIME_MS = 30;
    localparam int US_PER_MS = 1000;
    localparam int TIMER_W = 23;
    // =====================================
    // bus map: bit 16 set selects the control registers
    localparam int ADDR_W = 17;
    localparam int ARR_AW = 14;
    localparam int SECT_LSB = 12;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 17'h10000;
    localparam logic [ADDR_W-1:0] STAT_OFS = 17'h10001;
    localparam logic [1:0] FLASH_HI = 2'h3;
    localparam int KEY_LSB = 4;
    localparam int TOGGLE_BIT = 6;
    localparam logic [3:0] KEY_ON = 4'h3;
    localparam logic [3:0] KEY_OFF = 4'hc;
    // =====================================
    // command cycles
    localparam logic [11:0] CMD_A1 = 12'h555;
    localparam logic [11:0] CMD_A2 = 12'haaa;
    localparam logic [7:0] D_UNLOCK1 = 8'haa;
    localparam logic [7:0] D_UNLOCK2 = 8'h55;
    localparam logic [7:0] D_PROG = 8'ha0;
    localparam logic [7:0] D_ERASE = 8'h80;
    localparam logic [7:0] D_SECT = 8'h30;
    localparam logic [7:0] D_CHIP = 8'h10;
    localparam logic [7:0] D_ID = 8'h90;
    localparam logic [7:0] D_EXIT = 8'hf0;
    localparam logic [7:0] D_SECURE = 8'ha5;
    localparam logic [7:0] D_SECURE_VAL = 8'h00;
    // =====================================
    // identification mode
    localparam logic [15:0] ID_VENDOR_ADR = 16'hf000;
    localparam logic [15:0] ID_MACRO_ADR = 16'hf001;
    localparam logic [15:0] ID_SIZE_ADR = 16'hf002;
    localparam logic [15:0] SECURE_ADR = 16'hff7f;
    // size codes: 60k 0e, 48k 0b, 32k 07, 24k 05, 16k 03, 8k 01, 4k 00
    localparam logic [7:0] SIZE_16K = 8'h03;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] PROT_OFF_VAL = 8'hff;
    localparam logic [7:0] PROT_ON_VAL = 8'h00;
    // =====================================
    // read pipeline
    localparam logic [1:0] RD_IDLE = 2'h0;
    localparam logic [1:0] RD_FETCH = 2'h1;
    localparam logic [1:0] RD_DONE = 2'h2;
    typedef enum logic [1:0] {MODE_MCU = 2'h0, MODE_SERIAL = 2'h1, MODE_PARALLEL = 2'h2} fcs_mode_t;
    typedef enum logic [8:0] {
        S_IDLE = 9'h001, S_U1 = 9'h002, S_U2 = 9'h004, S_E3 = 9'h008, S_E4 = 9'h010,
        S_E5 = 9'h020, S_PWAIT = 9'h040, S_SWAIT = 9'h080, S_BUSY = 9'h100
    } fcs_seq_t;
    typedef enum logic [4:0] {
        OP_NONE = 5'h01, OP_PROG = 5'h02, OP_SECT = 5'h04, OP_CHIP = 5'h08, OP_SECURE = 5'h10
    } fcs_op_t;
endpackage

// ### logic/fcs_array.sv
`timescale 1ns/1ps
module fcs_array #(
    parameter int AW = 14,
    parameter int DW = 8
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    // =====================================
    // storage, registered read; contents are not reset
    logic [DW-1:0] mem [0:(1<<AW)-1];

    generate
        if (AW < 1 || DW < 1) begin : g_bad
            $error("fcs_array: bad size");
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// ### logic/fcs_timer.sv
`timescale 1ns/1ps
module fcs_timer #(
    parameter int TW = 23
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic [TW-1:0] i_count,
    output logic o_busy
);
    typedef struct packed {
        logic [TW-1:0] cnt;
        logic busy;
    } fcs_tmr_t;

    fcs_tmr_t cur;
    fcs_tmr_t nx;

    generate
        if (TW < 1) begin : g_bad
            $error("fcs_timer: bad width");
        end
    endgenerate

    // =====================================
    // busy for exactly i_count cycles after the start edge
    always_comb begin
        nx = cur;
        if (i_start) begin
            nx.cnt = i_count - {{(TW-1){1'b0}}, 1'b1};
            nx.busy = 1'b1;
        end else if (cur.busy) begin
            if (cur.cnt == '0) begin
                nx.busy = 1'b0;
            end else begin
                nx.cnt = cur.cnt - {{(TW-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cur <= '0;
        end else begin
            cur <= nx;
        end
    end

    assign o_busy = cur.busy;
endmodule

// ### logic/fcs_sequencer.sv
`timescale 1ns/1ps
// Operation
// R1 - match commands on low twelve address bits
// R2 - AA/555, 55/AAA, A0/555 then byte program
// R3 - byte program finishes within forty microseconds
// R4 - six-write sector erase, top bits pick sector
// R5 - sector erase finishes within thirty milliseconds
// R6 - five opening writes, 10/555 erases chip
// R7 - erased chip reads FF everywhere
// R8 - no new command while operation runs
// R9 - bit six inverts on each busy read
// R10 - first status read after start returns one
// R11 - software polls until two reads match
// R12 - AA/555, 55/AAA, 90/555 enters identification
// R13 - identification codes at F000, F001, F002
// R14 - size code 03 for sixteen kbytes
// R15 - FF7F reads FF unless read-protected
// R16 - F0 anywhere or unlocked F0/555 exits
// R17 - A5/555 then 00/FF7F sets read protection
// R18 - protection blocks parallel reads, serial writes
// R19 - only chip erase clears read protection; the code also clears it on reset
// R20 - sector erase refused in parallel mode
// R21 - flash reads unavailable while busy
// R22 - software erases before reprogramming any byte
// R23 - commands act only with key 0011
// R24 - key resets to 1100
// R25 - mismatching write abandons the partial sequence
module fcs_sequencer import fcs_pkg::*; #(
    parameter int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ,
    parameter int unsigned ERASE_CYC = ERASE_TIME_MS * US_PER_MS * CLK_MHZ,
    parameter logic [7:0] VENDOR_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] MACRO_ID = 8'h2c // arbitrary value
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [7:0] i_avs_writedata,
    output logic [7:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [1:0] i_prog_mode,
    output logic o_flash_busy,
    output logic o_serial_load_refused
);
    typedef struct packed {
        fcs_seq_t st;
        fcs_op_t op;
        logic id_mode;
        logic prot;
        logic [3:0] key;
        logic toggle;
        logic [1:0] rd_cnt;
        logic [ADDR_W-1:0] ra;
        logic [7:0] rdata;
        logic we;
        logic [ARR_AW-1:0] waddr;
        logic [7:0] wdata;
        logic walk;
        logic [ARR_AW-1:0] walk_end;
        logic tstart;
        logic [TIMER_W-1:0] tcount;
    } fcs_state_t;

    localparam fcs_state_t RST_STATE = '{
        st: S_IDLE, op: OP_NONE, id_mode: 1'b0, prot: 1'b0, key: KEY_OFF, toggle: 1'b0,
        rd_cnt: RD_IDLE, ra: '0, rdata: 8'h00, we: 1'b0, waddr: '0, wdata: 8'h00,
        walk: 1'b0, walk_end: '0, tstart: 1'b0, tcount: '0
    };

    generate
        if (PROG_CYC < 3 || ERASE_CYC < 3 || ERASE_CYC >= (64'h1 << TIMER_W)) begin : g_bad
            $error("fcs_sequencer: operation counts out of range");
        end
    endgenerate

    // =====================================
    // reset release
    logic [1:0] rst_pipe;
    logic rstn_sync;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rstn_sync = rst_pipe[1];

    // =====================================
    // decode
    fcs_state_t cur;
    fcs_state_t nx;
    logic [7:0] arr_rdata;
    logic tbusy;
    logic sel_flash;
    logic ra_flash;
    logic cmd_ok;
    logic is_u1;
    logic is_u2;
    logic [11:0] a12;

    assign sel_flash = !i_avs_address[ADDR_W-1] && (i_avs_address[15:14] == FLASH_HI);
    assign ra_flash = !cur.ra[ADDR_W-1] && (cur.ra[15:14] == FLASH_HI);
    assign cmd_ok = i_avs_write && sel_flash && (cur.key == KEY_ON); // R23
    assign a12 = i_avs_address[11:0]; // R1
    assign is_u1 = (a12 == CMD_A1) && (i_avs_writedata == D_UNLOCK1);
    assign is_u2 = (a12 == CMD_A2) && (i_avs_writedata == D_UNLOCK2);

    // =====================================
    // next state
    always_comb begin
        logic [7:0] rv;
        rv = 8'h00;
        nx = cur;
        nx.we = 1'b0;
        nx.tstart = 1'b0;

        if (i_avs_write && i_avs_address == CTRL_OFS) begin
            nx.key = i_avs_writedata[KEY_LSB +: 4];
        end

        // reads answer two cycles after they arrive; data leaves a flip-flop
        if (cur.rd_cnt == RD_IDLE && i_avs_read) begin
            nx.rd_cnt = RD_FETCH;
            nx.ra = i_avs_address;
        end else if (cur.rd_cnt == RD_FETCH) begin
            nx.rd_cnt = RD_DONE;
            if (cur.ra == CTRL_OFS) begin
                rv = {cur.key, 4'h0};
            end else if (cur.ra == STAT_OFS) begin
                rv = {5'h00, cur.id_mode, cur.prot, cur.st == S_BUSY};
            end else if (ra_flash) begin
                if (cur.st == S_BUSY) begin
                    rv[TOGGLE_BIT] = cur.toggle; // R21
                    nx.toggle = !cur.toggle; // R9
                end else if (cur.prot && i_prog_mode == MODE_PARALLEL) begin
                    rv = 8'h00; // R18
                end else if (cur.id_mode && cur.ra[15:0] == ID_VENDOR_ADR) begin
                    rv = VENDOR_ID; // R13
                end else if (cur.id_mode && cur.ra[15:0] == ID_MACRO_ADR) begin
                    rv = MACRO_ID; // R13
                end else if (cur.id_mode && cur.ra[15:0] == ID_SIZE_ADR) begin
                    rv = SIZE_16K; // R14
                end else if (cur.id_mode && cur.ra[15:0] == SECURE_ADR) begin
                    rv = cur.prot ? PROT_ON_VAL : PROT_OFF_VAL; // R15
                end else begin
                    rv = arr_rdata;
                end
            end
            nx.rdata = rv;
        end else if (cur.rd_cnt == RD_DONE) begin
            nx.rd_cnt = RD_IDLE;
        end

        // erase walk writes one byte per cycle
        if (cur.walk) begin
            if (cur.waddr == cur.walk_end) begin
                nx.walk = 1'b0;
            end else begin
                nx.we = 1'b1;
                nx.wdata = ERASED; // R7
                nx.waddr = cur.waddr + {{(ARR_AW-1){1'b0}}, 1'b1};
            end
        end

        unique case (cur.st)
            S_IDLE: begin
                if (cmd_ok && is_u1) begin
                    nx.st = S_U1;
                end else if (cmd_ok && cur.id_mode && i_avs_writedata == D_EXIT) begin
                    nx.id_mode = 1'b0; // R16
                end
            end
            S_U1: begin
                if (cmd_ok) begin
                    nx.st = is_u2 ? S_U2 : S_IDLE; // R25
                end
            end
            S_U2: begin
                if (cmd_ok) begin
                    nx.st = S_IDLE; // R25
                    if (a12 == CMD_A1 && cur.id_mode) begin
                        if (i_avs_writedata == D_EXIT) begin
                            nx.id_mode = 1'b0; // R16
                        end
                    end else if (a12 == CMD_A1) begin
                        if (i_avs_writedata == D_PROG) begin
                            nx.st = S_PWAIT; // R2
                        end else if (i_avs_writedata == D_ERASE) begin
                            nx.st = S_E3; // R4
                        end else if (i_avs_writedata == D_ID) begin
                            nx.id_mode = 1'b1; // R12
                        end else if (i_avs_writedata == D_SECURE) begin
                            nx.st = S_SWAIT; // R17
                        end
                    end
                end
            end
            S_E3: begin
                if (cmd_ok) begin
                    nx.st = is_u1 ? S_E4 : S_IDLE;
                end
            end
            S_E4: begin
                if (cmd_ok) begin
                    nx.st = is_u2 ? S_E5 : S_IDLE;
                end
            end
            S_E5: begin
                if (cmd_ok) begin
                    nx.st = S_IDLE;
                    // sector target keeps only address bits ARR_AW-1:SECT_LSB, any offset inside it
                    if (i_avs_writedata == D_SECT && i_prog_mode != MODE_PARALLEL) begin // R20
                        nx.st = S_BUSY; // R4
                        nx.op = OP_SECT;
                        nx.tstart = 1'b1;
                        nx.tcount = TIMER_W'(ERASE_CYC - 2); // R5
                        nx.toggle = 1'b1;
                        nx.walk = 1'b1;
                        nx.we = 1'b1;
                        nx.wdata = ERASED;
                        nx.waddr = {i_avs_address[ARR_AW-1:SECT_LSB], {SECT_LSB{1'b0}}};
                        nx.walk_end = {i_avs_address[ARR_AW-1:SECT_LSB], {SECT_LSB{1'b1}}};
                    end else if (i_avs_writedata == D_CHIP && a12 == CMD_A1) begin
                        nx.st = S_BUSY; // R6
                        nx.op = OP_CHIP;
                        nx.tstart = 1'b1;
                        nx.tcount = TIMER_W'(ERASE_CYC - 2);
                        nx.toggle = 1'b1; // R10
                        nx.walk = 1'b1;
                        nx.we = 1'b1;
                        nx.wdata = ERASED; // R7
                        nx.waddr = '0;
                        nx.walk_end = '1;
                    end
                end
            end
            S_PWAIT: begin
                if (cmd_ok) begin
                    nx.st = S_IDLE;
                    // a protected part in serial mode takes no byte writes
                    if (!(cur.prot && i_prog_mode == MODE_SERIAL)) begin // R18
                        nx.st = S_BUSY; // R2
                        nx.op = OP_PROG;
                        nx.tstart = 1'b1;
                        nx.tcount = TIMER_W'(PROG_CYC - 2); // R3
                        nx.toggle = 1'b1; // R10
                        nx.we = 1'b1;
                        nx.waddr = i_avs_address[ARR_AW-1:0];
                        nx.wdata = i_avs_writedata;
                    end
                end
            end
            S_SWAIT: begin
                if (cmd_ok) begin
                    nx.st = S_IDLE;
                    if (i_avs_address[15:0] == SECURE_ADR && i_avs_writedata == D_SECURE_VAL) begin
                        nx.st = S_BUSY; // R17
                        nx.op = OP_SECURE;
                        nx.tstart = 1'b1;
                        nx.tcount = TIMER_W'(PROG_CYC - 2);
                        nx.toggle = 1'b1; // R10
                    end
                end
            end
            S_BUSY: begin
                // command writes are simply dropped here
                if (!cur.tstart && !tbusy && !cur.walk) begin // R8
                    nx.st = S_IDLE;
                    nx.op = OP_NONE;
                    if (cur.op == OP_SECURE) begin
                        nx.prot = 1'b1; // R17
                    end else if (cur.op == OP_CHIP) begin
                        nx.prot = 1'b0; // R19
                    end
                end
            end
            default: begin
                nx.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rstn_sync) begin
        if (!rstn_sync) begin
            cur <= RST_STATE; // R24
        end else begin
            cur <= nx;
        end
    end

    // =====================================
    // array and operation timer
    fcs_array #(
        .AW(ARR_AW),
        .DW(8)
    ) u_array (
        .i_clk(i_sys_clk),
        .i_we(cur.we),
        .i_waddr(cur.waddr),
        .i_wdata(cur.wdata),
        .i_raddr(i_avs_address[ARR_AW-1:0]),
        .o_rdata(arr_rdata)
    );

    fcs_timer #(
        .TW(TIMER_W)
    ) u_timer (
        .i_clk(i_sys_clk),
        .i_rstn(rstn_sync),
        .i_start(cur.tstart),
        .i_count(cur.tcount),
        .o_busy(tbusy)
    );

    assign o_avs_readdata = cur.rdata;
    assign o_avs_waitrequest = i_avs_read && (cur.rd_cnt != RD_DONE);
    assign o_flash_busy = (cur.st == S_BUSY); // R21
    assign o_serial_load_refused = cur.prot && (i_prog_mode == MODE_SERIAL); // R18

    // =====================================
    // checks
    logic [31:0] busy_cnt;

    always_ff @(posedge i_sys_clk or negedge rstn_sync) begin
        if (!rstn_sync) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= (cur.st == S_BUSY) ? busy_cnt + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rstn_sync);

    property p_key_gate;
        (cur.st == S_IDLE && i_avs_write && sel_flash && cur.key != KEY_ON) |=> cur.st == S_IDLE;
    endproperty
    a_key_gate: assert property (p_key_gate) else $error("command taken while key locked"); // R23

    property p_key_reset;
        !$past(rstn_sync) |-> cur.key == KEY_OFF;
    endproperty
    a_key_reset: assert property (p_key_reset) else $error("key not locked after reset"); // R24

    property p_prog_entry;
        (cur.st == S_U2 && cmd_ok && !cur.id_mode && a12 == CMD_A1 && i_avs_writedata == D_PROG)
            |=> cur.st == S_PWAIT ##1 (cur.st == S_PWAIT)[*1];
    endproperty
    a_prog_entry: assert property (p_prog_entry) else $error("program unlock not recognised"); // R2

    property p_prog_time;
        (cur.st == S_BUSY && cur.op == OP_PROG) |-> busy_cnt < PROG_CYC;
    endproperty
    a_prog_time: assert property (p_prog_time) else $error("byte program too long"); // R3

    // bound is the rule's limit, not ERASE_CYC: with short counts the 4096-byte walk is the longer part
    property p_erase_time;
        (cur.st == S_BUSY && cur.op == OP_SECT) |-> busy_cnt < ERASE_TIME_MS * US_PER_MS * CLK_MHZ;
    endproperty
    a_erase_time: assert property (p_erase_time) else $error("sector erase too long"); // R5

    property p_busy_holds;
        (cur.st == S_BUSY && (tbusy || cur.walk)) |=> cur.st == S_BUSY;
    endproperty
    a_busy_holds: assert property (p_busy_holds) else $error("left busy early"); // R8

    property p_first_one;
        (cur.st != S_BUSY && nx.st == S_BUSY) |=> cur.toggle ##1 cur.st == S_BUSY;
    endproperty
    a_first_one: assert property (p_first_one) else $error("first toggle read not one"); // R10

    property p_toggle_read;
        (cur.rd_cnt == RD_FETCH && ra_flash && cur.st == S_BUSY)
            |=> o_avs_readdata[TOGGLE_BIT] == $past(cur.toggle) && cur.toggle != $past(cur.toggle);
    endproperty
    a_toggle_read: assert property (p_toggle_read) else $error("toggle bit did not alternate"); // R9

    property p_prot_clear;
        $fell(cur.prot) |-> $past(cur.op) == OP_CHIP;
    endproperty
    a_prot_clear: assert property (p_prot_clear) else $error("protection cleared without chip erase"); // R19

    property p_vendor;
        (cur.rd_cnt == RD_FETCH && cur.id_mode && cur.st != S_BUSY && cur.ra == {1'b0, ID_VENDOR_ADR}
            && !(cur.prot && i_prog_mode == MODE_PARALLEL)) |=> o_avs_readdata == VENDOR_ID;
    endproperty
    a_vendor: assert property (p_vendor) else $error("wrong vendor code"); // R13

    property p_abandon;
        (cur.st == S_U1 && cmd_ok && !is_u2) |=> cur.st == S_IDLE;
    endproperty
    a_abandon: assert property (p_abandon) else $error("bad write kept sequence"); // R25

    c_prog: cover property (cur.st == S_BUSY && cur.op == OP_PROG ##1 cur.st == S_IDLE);
    c_chip: cover property (cur.st == S_BUSY && cur.op == OP_CHIP ##1 cur.st == S_IDLE);
    c_id: cover property ($rose(cur.id_mode));
    c_secure: cover property ($rose(cur.prot));
endmodule

// ### verification/fcs_cpu_model.sv
`timescale 1ns/1ps
module fcs_cpu_model import fcs_pkg::*; (
    input wire logic i_clk,
    output logic [ADDR_W-1:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [7:0] o_writedata,
    input wire logic [7:0] i_readdata,
    input wire logic i_waitrequest
);
    // ====================
    // bus cycles; released lines show the inverse, never a stale copy
    initial begin
        o_address = '0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = '0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        o_address <= a;
        o_writedata <= d;
        o_write <= 1'b1;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        o_write <= 1'b0;
        o_address <= ~a;
        o_writedata <= ~d;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        o_address <= a;
        o_read <= 1'b1;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        d = i_readdata;
        o_read <= 1'b0;
        o_address <= ~a;
        @(posedge i_clk);
    endtask
    // nib is the area select; the matcher ignores its low two bits, its top two must be 11
    task automatic cmd3(input logic [3:0] nib, input logic [7:0] c);
        wr({1'b0, nib, CMD_A1}, D_UNLOCK1);
        wr({1'b0, nib, CMD_A2}, D_UNLOCK2);
        wr({1'b0, nib, CMD_A1}, c);
    endtask
    task automatic erase(input logic [ADDR_W-1:0] a, input logic [7:0] c);
        cmd3(4'hf, D_ERASE);
        wr(17'h0f555, D_UNLOCK1);
        wr(17'h0faaa, D_UNLOCK2);
        wr(a, c);
    endtask
    task automatic poll(input logic [ADDR_W-1:0] a, output logic [7:0] first, output int n);
        logic [7:0] p;
        logic [7:0] c;
        rd(a, p);
        first = p;
        n = 1;
        forever begin
            rd(a, c);
            n++;
            if (c === p) return;
            p = c;
        end
    endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import fcs_pkg::*; ;
    typedef struct {
        logic [ADDR_W-1:0] a;
        logic [7:0] d;
    } fcs_row_t;
    localparam logic [7:0] VEN = 8'h5a; // arbitrary value
    localparam logic [7:0] MAC = 8'h2c; // arbitrary value
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [1:0] prog_mode = 2'h0;
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [7:0] writedata;
    logic [7:0] readdata;
    logic waitrequest;
    logic busy;
    logic refused;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] f;
    int n;
    fcs_row_t rows[5] = '{'{17'h0f000, VEN}, '{17'h0f001, MAC}, '{17'h0f002, 8'h03},
        '{17'h0ff7f, 8'hff}, '{17'h0c100, 8'h3c}};

    always #2.5 i_sys_clk = ~i_sys_clk;

    // short busy counts keep the run small
    fcs_sequencer #(.PROG_CYC(20), .ERASE_CYC(40), .VENDOR_ID(VEN), .MACRO_ID(MAC)) u_dut (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_address(address), .i_avs_read(read),
        .i_avs_write(write), .i_avs_writedata(writedata), .o_avs_readdata(readdata),
        .o_avs_waitrequest(waitrequest), .i_prog_mode(prog_mode), .o_flash_busy(busy),
        .o_serial_load_refused(refused));
    fcs_cpu_model u_cpu (
        .i_clk(i_sys_clk), .o_address(address), .o_read(read), .o_write(write),
        .o_writedata(writedata), .i_readdata(readdata), .i_waitrequest(waitrequest));

    // ====================
    // checks and verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_cpu.rd(a, d);
        chk(d, exp);
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // two chip erases dominate, about 33k cycles
    initial begin
        #400us;
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        rchk(CTRL_OFS, 8'hc0);
        u_cpu.cmd3(4'hf, 8'ha0);
        u_cpu.wr(17'h0c100, 8'h77);
        chk({7'h0, busy}, 8'h00);
        u_cpu.wr(CTRL_OFS, 8'h3f);
        rchk(CTRL_OFS, 8'h30);
        u_cpu.erase(17'h0f555, 8'h10);
        chk({7'h0, busy}, 8'h01);
        u_cpu.poll(17'h0c000, f, n);
        chk(f & 8'h40, 8'h40);
        chk({7'h0, n > 2 && n < 4200}, 8'h01);
        rchk(17'h0c000, 8'hff);
        rchk(17'h0ffff, 8'hff);
        // second sequence lands while the first program still runs
        u_cpu.cmd3(4'hf, 8'ha0);
        u_cpu.wr(17'h0c100, 8'h3c);
        u_cpu.cmd3(4'hf, 8'ha0);
        u_cpu.wr(17'h0c200, 8'h11);
        u_cpu.poll(17'h0c100, f, n);
        chk({7'h0, n < 9}, 8'h01);
        rchk(17'h0c100, 8'h3c);
        rchk(17'h0c200, 8'hff);
        u_cpu.cmd3(4'hf, 8'h12);
        u_cpu.wr(17'h0c300, 8'h00);
        chk({7'h0, busy}, 8'h00);
        // a repeated first unlock breaks the sequence, so the following program is not taken
        u_cpu.wr(17'h0f555, 8'haa);
        u_cpu.cmd3(4'hf, 8'ha0);
        u_cpu.wr(17'h0c300, 8'h00);
        chk({7'h0, busy}, 8'h00);
        rchk(17'h0c300, 8'hff);
        u_cpu.cmd3(4'hd, 8'ha0);
        u_cpu.wr(17'h0e010, 8'h5a);
        u_cpu.poll(17'h0e010, f, n);
        rchk(17'h0e010, 8'h5a);
        prog_mode <= 2'h2;
        u_cpu.erase(17'h0e000, 8'h30);
        chk({7'h0, busy}, 8'h00);
        prog_mode <= 2'h0;
        u_cpu.erase(17'h0e000, 8'h30);
        u_cpu.poll(17'h0e010, f, n);
        chk({7'h0, n < 1100}, 8'h01);
        rchk(17'h0e010, 8'hff);
        rchk(17'h0c100, 8'h3c);
        u_cpu.cmd3(4'hf, 8'h90);
        foreach (rows[i]) rchk(rows[i].a, rows[i].d);
        u_cpu.wr(17'h0c000, 8'hf0);
        rchk(17'h0f000, 8'hff);
        u_cpu.cmd3(4'hf, 8'h90);
        u_cpu.cmd3(4'hf, 8'hf0);
        rchk(17'h0f001, 8'hff);
        u_cpu.cmd3(4'hf, 8'ha5);
        u_cpu.wr(17'h0ff7f, 8'h00);
        u_cpu.poll(17'h0c000, f, n);
        chk(f & 8'h40, 8'h40);
        chk({7'h0, n < 9}, 8'h01);
        rchk(STAT_OFS, 8'h02);
        u_cpu.cmd3(4'hf, 8'h90);
        rchk(17'h0ff7f, 8'h00);
        u_cpu.wr(17'h0c000, 8'hf0);
        prog_mode <= 2'h1;
        repeat (2) @(posedge i_sys_clk);
        chk({7'h0, refused}, 8'h01);
        // protected part in serial mode must drop the byte program
        u_cpu.cmd3(4'hf, 8'ha0);
        u_cpu.wr(17'h0c200, 8'h11);
        chk({7'h0, busy}, 8'h00);
        prog_mode <= 2'h2;
        rchk(17'h0c100, 8'h00);
        prog_mode <= 2'h0;
        u_cpu.erase(17'h0f555, 8'h10);
        u_cpu.poll(17'h0c000, f, n);
        rchk(STAT_OFS, 8'h00);
        rchk(17'h0c100, 8'hff);
        summarize();
    end
endmodule
